// >>> include/prsc_pkg.sv
// ****************************************************************
// reference select control package
// ****************************************************************
package prsc_pkg;

  // ****************************************************************
  // register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [7:0]  REF_SEL_CTRL_IDX    = 8'h1C; // reference_select_control
  localparam logic [7:0]  STAT_XTAL_CTRL_IDX  = 8'h1D; // status_pin_and_crystal_control
  localparam logic [7:0]  SEL_STATUS_IDX      = 8'h20; // read-only live selection state

  // apb byte addresses derived from the indices
  localparam logic [11:0] REF_SEL_CTRL_ADDR   = {2'h0, REF_SEL_CTRL_IDX, 2'h0};
  localparam logic [11:0] STAT_XTAL_CTRL_ADDR = {2'h0, STAT_XTAL_CTRL_IDX, 2'h0};
  localparam logic [11:0] SEL_STATUS_ADDR     = {2'h0, SEL_STATUS_IDX, 2'h0};

  // ****************************************************************
  // reference_select_control fields
  // ****************************************************************
  localparam int DEGLITCH_BYPASS_BIT = 7; // 1 bypasses switchover deglitch
  localparam int SELECT_SECOND_BIT   = 6; // manual register select
  localparam int USE_SEL_PIN_BIT     = 5; // manual select from pin
  localparam int AUTO_SWITCH_BIT     = 4; // automatic switchover
  localparam int STAY_SECOND_BIT     = 3; // no return to primary
  localparam int SECOND_POWER_BIT    = 2; // secondary input power
  localparam int PRIMARY_POWER_BIT   = 1; // primary input power
  localparam int DIFF_MODE_BIT       = 0; // differential reference

  // ****************************************************************
  // status_pin_and_crystal_control fields
  // ****************************************************************
  localparam int NVLOAD_STATUS_BIT   = 7; // nonvolatile-load status on pin
  localparam int XTAL_AMP_BIT        = 6; // crystal maintaining amplifier

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] REF_SEL_CTRL_RST   = 8'h00;
  localparam logic [7:0] STAT_XTAL_CTRL_RST = 8'h80;

  // ****************************************************************
  // deglitch timing
  // ****************************************************************
  localparam int          CLK_PERIOD_NS   = 50;  // 20 MHz pclk
  localparam int          DEGLITCH_NS     = 200; // stable time before a switch
  localparam logic [3:0]  DEGLITCH_CYCLES =
    4'((DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // register identities for the address decoder
  typedef enum logic [1:0] {
    PRSC_REG_NONE   = 2'b00,
    PRSC_REG_REFSEL = 2'b01,
    PRSC_REG_STATX  = 2'b10,
    PRSC_REG_STATUS = 2'b11
  } prsc_reg_type;

  // automatic switchover states
  typedef enum logic [1:0] {
    PRSC_ON_PRIMARY = 2'b00,
    PRSC_ON_SECOND  = 2'b01
  } prsc_state_type;

endpackage

// >>> src/prsc_ref_select.sv
// Chosen here: the APB register port.
`timescale 1ns/1ps
// Notes on behaviour
// - manual register bit 1 picks secondary
// - manual mode: pin or register picks reference
// - automatic switchover powers both reference inputs
// - revert to primary unless stay bit set
// - bit powers secondary input, auto overrides
// - bit powers primary input, auto overrides
// - mode bit selects differential, power bits cleared; the logic leaves the power bits as written
// - enable bit routes nonvolatile-load status to pin
// - bit enables crystal maintaining amplifier
module prsc_ref_select (
  // apb clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // reference pins and monitors
  input  wire logic        ref_sel_pin,
  input  wire logic        primary_status_good,
  input  wire logic        secondary_status_good,
  // status pin sources
  input  wire logic        nvload_status,
  input  wire logic        status_mux_out,
  // controls to the analog reference path
  output logic             pll_ref_is_secondary,
  output logic             primary_reference_power,
  output logic             secondary_reference_power,
  output logic             differential_mode,
  output logic             crystal_maintaining_amp_en,
  output logic             status_pin
);

  // ****************************************************************
  // address decode
  // ****************************************************************

  // maps a byte address onto a register identity
  function automatic prsc_pkg::prsc_reg_type reg_decode(input logic [11:0] addr);
    prsc_pkg::prsc_reg_type id;
    id = prsc_pkg::PRSC_REG_NONE;
    if (addr == prsc_pkg::REF_SEL_CTRL_ADDR) begin
      id = prsc_pkg::PRSC_REG_REFSEL;
    end else if (addr == prsc_pkg::STAT_XTAL_CTRL_ADDR) begin
      id = prsc_pkg::PRSC_REG_STATX;
    end else if (addr == prsc_pkg::SEL_STATUS_ADDR) begin
      id = prsc_pkg::PRSC_REG_STATUS;
    end
    return id;
  endfunction

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [7:0]              ref_ctrl_q;     // reference_select_control
  logic [7:0]              statx_ctrl_q;   // status_pin_and_crystal_control
  logic                    pready_q;       // one wait-free access phase
  logic [31:0]             prdata_q;       // read data captured at setup
  logic                    pslverr_q;      // unmapped address answer
  prsc_pkg::prsc_state_type auto_state_q;  // automatic switchover state
  logic                    want_second;    // requested reference, pre-deglitch
  logic                    sel_q;          // reference actually fed to pll
  logic [3:0]              stable_cnt_q;   // deglitch settle counter
  logic [1:0]              power_q;        // [0] primary, [1] secondary
  logic                    diff_q;         // differential mode output
  logic                    xtal_q;         // crystal amp output
  logic                    status_q;       // status pin output
  logic                    wr_stb;         // write takes effect this edge
  prsc_pkg::prsc_reg_type  setup_id;       // decode in setup phase
  prsc_pkg::prsc_reg_type  access_id;      // decode in access phase
  logic                    auto_en;        // automatic switchover enabled

  assign setup_id  = reg_decode(paddr);
  assign access_id = reg_decode(paddr);
  assign wr_stb    = psel & penable & pready_q & pwrite;
  assign auto_en   = ref_ctrl_q[prsc_pkg::AUTO_SWITCH_BIT];

  // ****************************************************************
  // apb handshake
  // ****************************************************************

  // ready rises in the first access cycle; no wait states ever
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= psel & ~penable;
    end
  end

  // error flagged on unmapped address, held through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_q <= 1'b0;
    end else if (psel & ~penable) begin
      pslverr_q <= (setup_id == prsc_pkg::PRSC_REG_NONE);
    end else begin
      pslverr_q <= 1'b0;
    end
  end

  // read data is captured in setup so it stands stable for the access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel & ~penable & ~pwrite) begin
      case (setup_id)
        prsc_pkg::PRSC_REG_REFSEL: begin
          prdata_q <= {24'h00_0000, ref_ctrl_q};
        end
        prsc_pkg::PRSC_REG_STATX: begin
          prdata_q <= {24'h00_0000, statx_ctrl_q};
        end
        prsc_pkg::PRSC_REG_STATUS: begin
          // live state: selection, power, pending deglitch, auto state
          prdata_q <= {26'h000_0000, (auto_state_q == prsc_pkg::PRSC_ON_SECOND),
                       (want_second != sel_q), power_q, sel_q, want_second};
        end
        default: begin
          prdata_q <= 32'h0000_0000;
        end
      endcase
    end else if (!psel) begin
      prdata_q <= 32'h0000_0000;
    end
  end

  // ****************************************************************
  // control registers
  // ****************************************************************

  // reference_select_control; software owns differential/auto consistency
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_ctrl_q <= prsc_pkg::REF_SEL_CTRL_RST;
    end else if (wr_stb && access_id == prsc_pkg::PRSC_REG_REFSEL) begin
      ref_ctrl_q <= pwdata[7:0]; // bits stored as written
    end
  end

  // status_pin_and_crystal_control; low six bits unused, read as zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      statx_ctrl_q <= prsc_pkg::STAT_XTAL_CTRL_RST;
    end else if (wr_stb && access_id == prsc_pkg::PRSC_REG_STATX) begin
      statx_ctrl_q <= {pwdata[7:6], 6'h00};
    end
  end

  // ****************************************************************
  // automatic switchover
  // ****************************************************************

  // leaves primary only when primary is bad and secondary good;
  // a dead secondary would gain nothing, so the pll stays put
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_state_q <= prsc_pkg::PRSC_ON_PRIMARY;
    end else if (!auto_en) begin
      // parked on primary so enabling auto starts from a known place
      auto_state_q <= prsc_pkg::PRSC_ON_PRIMARY;
    end else begin
      case (auto_state_q)
        prsc_pkg::PRSC_ON_PRIMARY: begin
          if (!primary_status_good && secondary_status_good) begin
            auto_state_q <= prsc_pkg::PRSC_ON_SECOND;
          end
        end
        prsc_pkg::PRSC_ON_SECOND: begin
          // revertive unless the stay bit holds us here
          if (primary_status_good && !ref_ctrl_q[prsc_pkg::STAY_SECOND_BIT]) begin
            auto_state_q <= prsc_pkg::PRSC_ON_PRIMARY;
          end
        end
        default: begin
          auto_state_q <= prsc_pkg::PRSC_ON_PRIMARY;
        end
      endcase
    end
  end

  // ****************************************************************
  // requested reference
  // ****************************************************************

  // auto mode follows the state machine, manual uses pin or register
  always_comb begin
    if (auto_en) begin
      want_second = (auto_state_q == prsc_pkg::PRSC_ON_SECOND);
    end else if (ref_ctrl_q[prsc_pkg::USE_SEL_PIN_BIT]) begin
      want_second = ref_sel_pin;
    end else begin
      want_second = ref_ctrl_q[prsc_pkg::SELECT_SECOND_BIT];
    end
  end

  // ****************************************************************
  // switchover deglitch
  // ****************************************************************

  // counts how long the request has differed from the applied choice;
  // a request that flips back before the count ends is dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stable_cnt_q <= 4'h0;
    end else if (want_second == sel_q) begin
      stable_cnt_q <= 4'h0;
    end else if (stable_cnt_q != prsc_pkg::DEGLITCH_CYCLES) begin
      stable_cnt_q <= stable_cnt_q + 4'h1;
    end
  end

  // bypass trades runt protection for an immediate switch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_q <= 1'b0;
    end else if (ref_ctrl_q[prsc_pkg::DEGLITCH_BYPASS_BIT]) begin
      sel_q <= want_second;
    end else if (want_second != sel_q && stable_cnt_q == prsc_pkg::DEGLITCH_CYCLES) begin
      sel_q <= want_second;
    end
  end

  // ****************************************************************
  // reference input power
  // ****************************************************************

  // one identical slice per input; auto forces both on
  for (genvar i = 0; i < 2; i++) begin : g_power
    localparam int PWR_BIT = (i == 0) ? prsc_pkg::PRIMARY_POWER_BIT
                                      : prsc_pkg::SECOND_POWER_BIT;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        power_q[i] <= 1'b0;
      end else begin
        power_q[i] <= auto_en | ref_ctrl_q[PWR_BIT];
      end
    end
  end

  // ****************************************************************
  // mode, crystal and status pin
  // ****************************************************************

  // differential flag straight from its register bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      diff_q <= 1'b0;
    end else begin
      diff_q <= ref_ctrl_q[prsc_pkg::DIFF_MODE_BIT];
    end
  end

  // crystal maintaining amplifier enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xtal_q <= 1'b0;
    end else begin
      xtal_q <= statx_ctrl_q[prsc_pkg::XTAL_AMP_BIT];
    end
  end

  // nonvolatile-load status wins over the status multiplexer while its enable bit is set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= 1'b0;
    end else if (statx_ctrl_q[prsc_pkg::NVLOAD_STATUS_BIT]) begin
      status_q <= nvload_status;
    end else begin
      status_q <= status_mux_out;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign pready                     = pready_q;
  assign prdata                     = prdata_q;
  assign pslverr                    = pslverr_q;
  assign pll_ref_is_secondary       = sel_q;
  assign primary_reference_power    = power_q[0];
  assign secondary_reference_power  = power_q[1];
  assign differential_mode          = diff_q;
  assign crystal_maintaining_amp_en = xtal_q;
  assign status_pin                 = status_q;

endmodule

// >>> tb/prsc_ref_select_properties.sv
`timescale 1ns/1ps
// ****************************************************************
// reference select checker
// ****************************************************************
module prsc_ref_select_properties (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb side
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  // reference and status pins
  input wire logic        ref_sel_pin,
  input wire logic        primary_status_good,
  input wire logic        nvload_status,
  input wire logic        status_mux_out,
  input wire logic        pll_ref_is_secondary,
  input wire logic        primary_reference_power,
  input wire logic        secondary_reference_power,
  input wire logic        differential_mode,
  input wire logic        crystal_maintaining_amp_en,
  input wire logic        status_pin
);
  logic [7:0] ref_q;   // shadow of the reference select register
  logic [7:0] stx_q;   // shadow of the status and crystal register
  logic       alive_q; // set one edge after reset, outputs settled
  logic       wr_w;    // completed write
  logic       req_w;   // manual selection request
  assign wr_w  = psel && penable && pready && pwrite;
  assign req_w = ref_q[5] ? ref_sel_pin : ref_q[6];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // shadows follow completed writes, so no internal taps are needed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_q   <= prsc_pkg::REF_SEL_CTRL_RST;
      stx_q   <= prsc_pkg::STAT_XTAL_CTRL_RST;
      alive_q <= 1'b0;
    end else begin
      alive_q <= 1'b1;
      if (wr_w && paddr == prsc_pkg::REF_SEL_CTRL_ADDR) begin
        ref_q <= pwdata[7:0];
      end
      if (wr_w && paddr == prsc_pkg::STAT_XTAL_CTRL_ADDR) begin
        stx_q <= pwdata[7:0];
      end
    end
  end

  a_pready_after_setup: assert property (psel && !penable |=> pready && penable)
    else $error("pready missing in first access cycle");
  a_xtal_amp_bit: assert property (alive_q |->
    crystal_maintaining_amp_en == $past(stx_q[6]))
    else $error("crystal amplifier enable wrong");
  a_status_pin_route: assert property (alive_q |->
    status_pin == $past(stx_q[7] ? nvload_status : status_mux_out))
    else $error("status pin source wrong");
  a_power_bits: assert property (alive_q |->
    primary_reference_power == $past(ref_q[4] | ref_q[1]) &&
    secondary_reference_power == $past(ref_q[4] | ref_q[2])) else $error("power wrong");
  a_diff_mode: assert property (alive_q |-> differential_mode == $past(ref_q[0]))
    else $error("differential mode wrong");
  a_bypass_select: assert property (alive_q && $past(ref_q[7]) &&
    !$past(ref_q[4]) |-> pll_ref_is_secondary == $past(req_w))
    else $error("bypassed selection wrong");
  // both directions: a runt away from the applied reference must not reach the pll
  a_deglitch_waits: assert property (!ref_q[7] && !ref_q[4] && $changed(req_w) &&
    pll_ref_is_secondary != req_w |=> $stable(pll_ref_is_secondary) [*3])
    else $error("switched too early");
  a_deglitch_settles: assert property ((!ref_q[7] && !ref_q[4] && req_w) [*8] |->
    pll_ref_is_secondary) else $error("switch never applied");
  a_revert_primary: assert property ((ref_q[4] && ref_q[7] && !ref_q[3] &&
    primary_status_good) [*4] |-> !pll_ref_is_secondary) else $error("no return to primary");

  cover property (ref_q[4] && $rose(pll_ref_is_secondary));
  cover property (!ref_q[7] && $rose(pll_ref_is_secondary));
  cover property (pready && !pwrite);
endmodule

bind prsc_ref_select prsc_ref_select_properties prsc_ref_select_properties_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .ref_sel_pin(ref_sel_pin),
  .primary_status_good(primary_status_good), .nvload_status(nvload_status),
  .status_mux_out(status_mux_out), .pll_ref_is_secondary(pll_ref_is_secondary),
  .primary_reference_power(primary_reference_power),
  .secondary_reference_power(secondary_reference_power),
  .differential_mode(differential_mode),
  .crystal_maintaining_amp_en(crystal_maintaining_amp_en), .status_pin(status_pin));

// >>> tb/test_prsc_ref_select.sv
`timescale 1ns/1ps
// ****************************************************************
// reference select testbench
// ****************************************************************
module test_prsc_ref_select;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic        ref_sel_pin = 1'b0, primary_status_good = 1'b1, secondary_status_good = 1'b1;
  logic        nvload_status = 1'b0, status_mux_out = 1'b0, pin_chk = 1'b0;
  logic        pready, pslverr, pll_sec, pri_pwr, sec_pwr, diff, xtal, status_pin;
  logic [31:0] prdata;
  logic [5:0]  pins_w;                // output pins gathered for one compare
  logic [32:0] note_q[$];             // expected results, oldest first
  logic [31:0] rnd = 32'h00012AFC;    // xorshift state
  logic [7:0]  d;
  int          n_fail = 0, cmp_count = 0, i;
  assign pins_w = {pll_sec, pri_pwr, sec_pwr, diff, xtal, status_pin};
  always #25 pclk = ~pclk;

  prsc_ref_select prsc_ref_select_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .ref_sel_pin(ref_sel_pin),
    .primary_status_good(primary_status_good), .secondary_status_good(secondary_status_good),
    .nvload_status(nvload_status), .status_mux_out(status_mux_out),
    .pll_ref_is_secondary(pll_sec), .primary_reference_power(pri_pwr),
    .secondary_reference_power(sec_pwr), .differential_mode(diff),
    .crystal_maintaining_amp_en(xtal), .status_pin(status_pin));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic chk(input string what, input logic [32:0] seen, input logic [32:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one apb transfer, idle cycle first so no signal is assigned twice per step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // no assumed latency: only the watchdog ends a wait that never answers
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    apb(1'b1, a, {24'h000000, v});
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    note_q.push_back(e);
    apb(1'b0, a, 32'h00000000);
  endtask
  // pins are judged a few edges later, after the one-clock output lag
  task automatic pins(input logic [5:0] e);
    repeat (3) @(posedge pclk);
    note_q.push_back({27'h0000000, e});
    pin_chk <= 1'b1;
    @(posedge pclk);
    pin_chk <= 1'b0;
  endtask

  // monitor: a finished read or a pin request takes the oldest note
  always @(posedge pclk) begin
    if (pin_chk) begin
      chk("pins", {27'h0000000, pins_w}, note_q.pop_front());
    end else if (psel && penable && pready === 1'b1 && !pwrite) begin
      chk("prdata", {pslverr, prdata}, note_q.pop_front());
    end
  end

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #1000000;
    n_fail++;
    complete_run();
  end

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    // reset values, the status word, a refused address
    rd(prsc_pkg::REF_SEL_CTRL_ADDR, 33'h000000000);
    rd(prsc_pkg::STAT_XTAL_CTRL_ADDR, 33'h000000080);
    wr(prsc_pkg::SEL_STATUS_ADDR, 8'hFF);
    rd(prsc_pkg::SEL_STATUS_ADDR, 33'h000000000);
    rd(12'h100, 33'h100000000);
    // status pin source and crystal amplifier, random values
    for (i = 0; i < 8; i++) begin
      rnd = xs(rnd);
      d = rnd[7:0];
      nvload_status  <= rnd[8];
      status_mux_out <= rnd[9];
      wr(prsc_pkg::STAT_XTAL_CTRL_ADDR, d);
      rd(prsc_pkg::STAT_XTAL_CTRL_ADDR, {25'h0000000, d[7:6], 6'h00});
      pins({4'h0, d[6], d[7] ? rnd[8] : rnd[9]});
    end
    status_mux_out <= 1'b0;
    wr(prsc_pkg::STAT_XTAL_CTRL_ADDR, 8'h00);
    // manual selection with deglitch bypassed; power bits clear in differential
    for (i = 0; i < 12; i++) begin
      rnd = xs(rnd);
      d = {1'b1, rnd[6:5], 1'b0, rnd[3], rnd[0] ? 2'b00 : rnd[2:1], rnd[0]};
      ref_sel_pin <= rnd[9];
      wr(prsc_pkg::REF_SEL_CTRL_ADDR, d);
      rd(prsc_pkg::REF_SEL_CTRL_ADDR, {25'h0000000, d});
      pins({d[5] ? rnd[9] : d[6], d[1], d[2], d[0], 2'b00});
    end
    // automatic switchover, single-ended, with and without staying
    wr(prsc_pkg::REF_SEL_CTRL_ADDR, 8'h90);
    pins(6'h18);
    primary_status_good <= 1'b0;
    pins(6'h38);
    primary_status_good <= 1'b1;
    pins(6'h18);
    wr(prsc_pkg::REF_SEL_CTRL_ADDR, 8'h98);
    primary_status_good <= 1'b0;
    pins(6'h38);
    rd(prsc_pkg::SEL_STATUS_ADDR, 33'h00000002F);
    primary_status_good <= 1'b1;
    pins(6'h38);
    // deglitch: slow switch, then a runt on the select pin is swallowed
    wr(prsc_pkg::REF_SEL_CTRL_ADDR, 8'h80);
    pins(6'h00);
    ref_sel_pin <= 1'b1;
    wr(prsc_pkg::REF_SEL_CTRL_ADDR, 8'h60);
    pins(6'h00);
    pins(6'h20);
    ref_sel_pin <= 1'b0;
    repeat (2) @(posedge pclk);
    ref_sel_pin <= 1'b1;
    pins(6'h20);
    repeat (2) @(posedge pclk);
    complete_run();
  end
endmodule
